/* verilog/rmmc_params.svh */
`ifndef RMMC_PARAMS_SVH
`define RMMC_PARAMS_SVH
// clock rate and timing figures
`define RMMC_CLK_MHZ 20
`define RMMC_GAP_US 2000
`define RMMC_RECFG_US 1000
`define RMMC_SLEEP_US 500000
`define RMMC_LISTEN_US 2000
`define RMMC_STABLE_CYC 4'h8
// mode-select pin codes
`define RMMC_MODE_PKT 3'h2
`define RMMC_MODE_CFGA 3'h3
`define RMMC_MODE_WAKE 3'h4
`define RMMC_MODE_CFGB 3'h5
`define RMMC_MODE_SAVE 3'h6
// packet limits
`define RMMC_WAKE_MAX 8'h54
`define RMMC_SUB_0 8'hF0
`define RMMC_SUB_1 8'h80
`define RMMC_SUB_2 8'h40
`define RMMC_SUB_3 8'h20
`define RMMC_HDR_BYTES 2'h3
`define RMMC_SUB_MSB 7
`define RMMC_SUB_LSB 5
`define RMMC_BCAST_LO 16'h0000
`define RMMC_BCAST_HI 16'hFFFF
// configuration command heads and trailing byte counts
`define RMMC_CMD_SAVE 8'hC0
`define RMMC_CMD_READ 8'hC1
`define RMMC_CMD_TEMP 8'hC2
`define RMMC_CMD_VER 8'hC3
`define RMMC_CMD_RST 8'hC4
`define RMMC_CMD_LONG 3'h5
`define RMMC_CMD_SHORT 3'h2
// register byte offsets
`define RMMC_REG_CTRL 8'h00
`define RMMC_REG_ADDR 8'h04
`define RMMC_REG_CHANNEL_CONFIG_BYTE 8'h08
`define RMMC_REG_WAKE 8'h0C
`define RMMC_REG_STAT 8'h10
// reset values
`define RMMC_RST_ADDR 16'h0000
`define RMMC_RST_CHANNEL_CONFIG_BYTE 8'h04
`define RMMC_RST_WAKE 16'h0010
`define RMMC_RST_FIXED 1'h0
`endif

/* verilog/rmmc_pkg.sv */
`default_nettype none
package rmmc_pkg;
    // main controller state
    typedef enum logic {ST_RUN, ST_RECFG} rmmc_state_t;
endpackage
`default_nettype wire

/* verilog/rmmc_top.sv */
// Contract
// - mode 010 allows radio send and receive; serial rate independent of air rate.
// - packet mode holds serial bytes until packet full or gap timeout, then sends.
// - addresses 0000 and FFFF are broadcast for receive and transmit.
// - packet mode payload capped by sub-packet size in channel byte bits 7:5.
// - mode 011 disables radio and drops serial bytes not used as config.
// - configuration modes use 9600 baud, 8 data bits, no parity, one stop.
// - leaving config applies parameters; busy indicator low until done.
// - mode 100 allows radio transmit, disables radio receive.
// - wake-up mode prepends preamble whose length is the wake-up time setting.
// - wake-up mode caps payload at 84 bytes, header bytes excluded.
// - mode 101 disables radio; every serial byte is a config command byte.
// - mode 110 never transmits; sleeps and wakes periodically to listen.
// - power-saving stays awake for a detected packet, outputs it, resumes.
// - power-saving accepts only packets carrying the wake-up preamble.
// - mode change acts only while idle, after transfers in progress finish.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`default_nettype none
`include "rmmc_params.svh"

module rmmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic room;
    wire push;
    wire pop;
    wire [CW-1:0] next_count;

    // handshake terms and occupancy
    assign push = i_in_valid && room;
    assign pop = i_out_ready && o_out_valid;
    assign next_count = o_count + CW'(push) - CW'(pop);
    assign o_in_ready = room; // straight from a flop, no gate after it
    assign o_out_valid = (o_count != '0);
    assign o_out_data = mem[rd_ptr];

    // storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers, count and registered room flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
            room <= 1'b1;
        end else begin
            wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
            rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
            o_count <= next_count;
            room <= (next_count != CW'(DEPTH));
        end
    end
endmodule

module rmmc_top
    import rmmc_pkg::*;
#(
    parameter int GAP_CYCLES = `RMMC_GAP_US * `RMMC_CLK_MHZ,
    parameter int RECFG_CYCLES = `RMMC_RECFG_US * `RMMC_CLK_MHZ,
    parameter int SLEEP_CYCLES = `RMMC_SLEEP_US * `RMMC_CLK_MHZ,
    parameter int LISTEN_CYCLES = `RMMC_LISTEN_US * `RMMC_CLK_MHZ
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_MODE_SELECT_BIT2,
    input wire logic I_MODE_SELECT_BIT1,
    input wire logic I_MODE_SELECT_BIT0,
    input wire logic I_SER_RX_VALID,
    input wire logic [7:0] I_SER_RX_DATA,
    output logic O_SER_RX_READY,
    output logic O_SER_TX_VALID,
    output logic [7:0] O_SER_TX_DATA,
    input wire logic I_SER_TX_READY,
    output logic O_UART_CFG_FIXED,
    output logic O_CFG_BYTE_VALID,
    output logic [7:0] O_CFG_BYTE,
    output logic O_RADIO_TX_VALID,
    output logic [7:0] O_RADIO_TX_DATA,
    input wire logic I_RADIO_TX_READY,
    output logic O_RADIO_TX_SEND,
    output logic O_RADIO_TX_WAKE,
    output logic [15:0] O_RADIO_WAKE_LEN,
    output logic O_RADIO_TX_BCAST,
    output logic [15:0] O_RADIO_TX_DEST,
    output logic O_RADIO_RX_ENABLE,
    input wire logic I_RADIO_RX_VALID,
    input wire logic [7:0] I_RADIO_RX_DATA,
    input wire logic [15:0] I_RADIO_RX_ADDR,
    input wire logic I_RADIO_RX_WAKE,
    input wire logic I_RADIO_RX_LAST,
    output logic O_RADIO_RX_READY,
    output logic O_IDLE,
    output logic [2:0] O_MODE
);
    // broadcast address test
    function automatic logic is_bcast(input logic [15:0] a);
        return (a == `RMMC_BCAST_LO) || (a == `RMMC_BCAST_HI);
    endfunction

    // configuration mode code test
    function automatic logic is_cfg_code(input logic [2:0] m);
        return (m == `RMMC_MODE_CFGA) || (m == `RMMC_MODE_CFGB);
    endfunction

    // sub-packet size lookup
    function automatic logic [7:0] sub_limit(input logic [2:0] code);
        case (code)
            3'h0: return `RMMC_SUB_0;
            3'h1: return `RMMC_SUB_1;
            3'h2: return `RMMC_SUB_2;
            default: return `RMMC_SUB_3;
        endcase
    endfunction

    // trailing byte count of a command head, zero if not a head
    function automatic logic [2:0] cmd_len(input logic [7:0] b);
        case (b)
            `RMMC_CMD_SAVE, `RMMC_CMD_TEMP: return `RMMC_CMD_LONG;
            `RMMC_CMD_READ, `RMMC_CMD_VER, `RMMC_CMD_RST: return `RMMC_CMD_SHORT;
            default: return 3'h0;
        endcase
    endfunction

    rmmc_state_t state;
    logic [2:0] sync1, sync2, sync3, cand, req_mode;
    logic [3:0] stab;
    logic [23:0] recfg_cnt, gap_cnt, wor_cnt;
    logic sh_fixed, act_fixed;
    logic [15:0] sh_addr, act_addr, sh_wake;
    logic [7:0] sh_channel_config_byte, act_channel_config_byte, pay_cnt;
    logic [1:0] hdr_left;
    logic [2:0] cmd_left;
    logic pkt_open, send_req, rx_busy, listen, wr_pend;
    logic [7:0] wr_addr;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [2:0] fifo_count;

    // mode decode
    wire is_pkt = (O_MODE == `RMMC_MODE_PKT);
    wire is_cfga = (O_MODE == `RMMC_MODE_CFGA);
    wire is_cfgb = (O_MODE == `RMMC_MODE_CFGB);
    wire is_wake = (O_MODE == `RMMC_MODE_WAKE);
    wire is_save = (O_MODE == `RMMC_MODE_SAVE);
    wire is_cfg = is_cfg_code(O_MODE);
    wire tx_mode = is_pkt || is_wake;
    wire in_run = (state == ST_RUN);

    // serial byte routing out of the fifo
    wire tx_room = !send_req && (!O_RADIO_TX_VALID || I_RADIO_TX_READY);
    wire fifo_pop = in_run && (tx_mode ? tx_room : 1'b1);
    wire take = fifo_pop && fifo_valid;
    wire take_tx = take && tx_mode;
    wire take_cfg = take && is_cfg;
    wire [2:0] head_len = cmd_len(fifo_data);
    wire cfg_keep = is_cfgb || (cmd_left != 3'h0) || (head_len != 3'h0);

    // packet assembly terms
    wire [1:0] eff_hdr = pkt_open ? hdr_left :
                         (act_fixed ? `RMMC_HDR_BYTES : 2'h0);
    wire is_hdr = (eff_hdr != 2'h0);
    wire [7:0] base_pay = pkt_open ? pay_cnt : 8'h00;
    wire [7:0] next_pay = base_pay + {7'h00, !is_hdr};
    wire [7:0] limit = is_wake ? `RMMC_WAKE_MAX :
                       sub_limit(act_channel_config_byte[`RMMC_SUB_MSB:`RMMC_SUB_LSB]);
    wire pay_hit = take_tx && !is_hdr && (next_pay == limit);
    wire gap_hit = pkt_open && !send_req && !take_tx &&
                   (gap_cnt == 24'(GAP_CYCLES - 1));
    wire fire = send_req && !O_RADIO_TX_VALID;

    // receive path terms
    wire addr_ok = is_bcast(act_addr) || is_bcast(I_RADIO_RX_ADDR) ||
                   (I_RADIO_RX_ADDR == act_addr);
    wire rx_ok = addr_ok && (!is_save || I_RADIO_RX_WAKE);
    wire rx_take = I_RADIO_RX_VALID && O_RADIO_RX_READY;
    wire next_ser_valid = (rx_take && rx_ok) ||
                          (O_SER_TX_VALID && !I_SER_TX_READY);
    wire rx_on = in_run && ((is_pkt) || (is_save && (listen || rx_busy)));

    // activity and mode switching
    wire busy_any = fifo_valid || pkt_open || send_req || rx_busy ||
                    O_RADIO_TX_VALID || O_SER_TX_VALID || O_RADIO_TX_SEND;
    wire switch_ok = in_run && O_IDLE && !busy_any &&
                     (req_mode != O_MODE);
    wire start_recfg = switch_ok && is_cfg && !is_cfg_code(req_mode);
    wire recfg_done = !in_run && (recfg_cnt == 24'(RECFG_CYCLES - 1));

    // bus decode
    wire ahb_sel = I_HSEL && I_HTRANS[1] && I_HREADY;
    wire [7:0] ra = I_HADDR[7:0];
    wire [31:0] stat_word = {21'h0, fifo_count, rx_busy, pkt_open,
                             send_req, !in_run, O_IDLE, O_MODE};
    wire [31:0] rd_word =
        (ra == `RMMC_REG_CTRL) ? {31'h0, sh_fixed} :
        (ra == `RMMC_REG_ADDR) ? {16'h0, sh_addr} :
        (ra == `RMMC_REG_CHANNEL_CONFIG_BYTE) ? {24'h0, sh_channel_config_byte} :
        (ra == `RMMC_REG_WAKE) ? {16'h0, sh_wake} :
        (ra == `RMMC_REG_STAT) ? stat_word : 32'h0;

    // serial input buffer
    rmmc_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
        .clk(I_MCLK),
        .rst_n(I_RST_N),
        .i_in_valid(I_SER_RX_VALID),
        .i_in_data(I_SER_RX_DATA),
        .o_in_ready(O_SER_RX_READY),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_pop),
        .o_count(fifo_count)
    );

    // mode pin synchroniser and stability filter
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            cand <= 3'h0;
            stab <= 4'h0;
            req_mode <= 3'h0;
        end else begin
            sync1 <= {I_MODE_SELECT_BIT2, I_MODE_SELECT_BIT1,
                      I_MODE_SELECT_BIT0};
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 != sync3) begin
                stab <= 4'h0;
            end else if (sync3 != cand) begin
                cand <= sync3;
                stab <= 4'h0;
            end else if (stab != `RMMC_STABLE_CYC) begin
                stab <= stab + 4'h1;
            end else begin
                req_mode <= cand;
            end
        end
    end

    // mode, reconfiguration and idle indicator
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            state <= ST_RUN;
            O_MODE <= 3'h0;
            recfg_cnt <= 24'h0;
            O_IDLE <= 1'b0;
            O_UART_CFG_FIXED <= 1'b0;
        end else begin
            O_IDLE <= in_run && !busy_any && !start_recfg;
            O_UART_CFG_FIXED <= is_cfg;
            recfg_cnt <= in_run ? 24'h0 : recfg_cnt + 24'h1;
            if (switch_ok) begin
                O_MODE <= req_mode;
            end
            if (start_recfg) begin
                state <= ST_RECFG;
            end else if (recfg_done) begin
                state <= ST_RUN;
            end
        end
    end

    // bus slave and software registers
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            O_HRDATA <= 32'h0;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            sh_fixed <= `RMMC_RST_FIXED;
            sh_addr <= `RMMC_RST_ADDR;
            sh_channel_config_byte <= `RMMC_RST_CHANNEL_CONFIG_BYTE;
            sh_wake <= `RMMC_RST_WAKE;
        end else begin
            wr_pend <= ahb_sel && I_HWRITE;
            wr_addr <= ra;
            O_HRDATA <= (ahb_sel && !I_HWRITE) ? rd_word : 32'h0;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
            if (wr_pend && wr_addr == `RMMC_REG_CTRL) begin
                sh_fixed <= I_HWDATA[0];
            end
            if (wr_pend && wr_addr == `RMMC_REG_ADDR) begin
                sh_addr <= I_HWDATA[15:0];
            end
            if (wr_pend && wr_addr == `RMMC_REG_CHANNEL_CONFIG_BYTE) begin
                sh_channel_config_byte <= I_HWDATA[7:0];
            end
            if (wr_pend && wr_addr == `RMMC_REG_WAKE) begin
                sh_wake <= I_HWDATA[15:0];
            end
        end
    end

    // working parameters take effect when reconfiguration ends
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            act_fixed <= `RMMC_RST_FIXED;
            act_addr <= `RMMC_RST_ADDR;
            act_channel_config_byte <= `RMMC_RST_CHANNEL_CONFIG_BYTE;
            O_RADIO_WAKE_LEN <= `RMMC_RST_WAKE;
        end else if (recfg_done) begin
            act_fixed <= sh_fixed;
            act_addr <= sh_addr;
            act_channel_config_byte <= sh_channel_config_byte;
            O_RADIO_WAKE_LEN <= sh_wake;
        end
    end

    // configuration byte handling
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cmd_left <= 3'h0;
            O_CFG_BYTE_VALID <= 1'b0;
            O_CFG_BYTE <= 8'h00;
        end else begin
            O_CFG_BYTE_VALID <= take_cfg && cfg_keep;
            O_CFG_BYTE <= take_cfg ? fifo_data : O_CFG_BYTE;
            if (!is_cfga) begin
                cmd_left <= 3'h0;
            end else if (take_cfg) begin
                cmd_left <= (cmd_left != 3'h0) ? cmd_left - 3'h1 : head_len;
            end
        end
    end

    // packet assembly and send trigger
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            pkt_open <= 1'b0;
            send_req <= 1'b0;
            hdr_left <= 2'h0;
            pay_cnt <= 8'h00;
            gap_cnt <= 24'h0;
            O_RADIO_TX_VALID <= 1'b0;
            O_RADIO_TX_DATA <= 8'h00;
            O_RADIO_TX_SEND <= 1'b0;
            O_RADIO_TX_WAKE <= 1'b0;
            O_RADIO_TX_BCAST <= 1'b0;
            O_RADIO_TX_DEST <= 16'h0;
        end else begin
            O_RADIO_TX_SEND <= fire;
            if (fire) begin
                O_RADIO_TX_WAKE <= is_wake;
                O_RADIO_TX_BCAST <= is_bcast(O_RADIO_TX_DEST);
            end
            if (take_tx) begin
                O_RADIO_TX_VALID <= 1'b1;
                O_RADIO_TX_DATA <= fifo_data;
            end else if (I_RADIO_TX_READY) begin
                O_RADIO_TX_VALID <= 1'b0;
            end
            gap_cnt <= (take_tx || !pkt_open) ? 24'h0 : gap_cnt + 24'h1;
            if (take_tx) begin
                pkt_open <= 1'b1;
                hdr_left <= is_hdr ? eff_hdr - 2'h1 : 2'h0;
                pay_cnt <= next_pay;
                if (!pkt_open && !act_fixed) begin
                    O_RADIO_TX_DEST <= act_addr;
                end else if (eff_hdr == 2'h3) begin
                    O_RADIO_TX_DEST[15:8] <= fifo_data;
                end else if (eff_hdr == 2'h2) begin
                    O_RADIO_TX_DEST[7:0] <= fifo_data;
                end
            end
            if (pay_hit || gap_hit) begin
                send_req <= 1'b1;
            end else if (fire) begin
                send_req <= 1'b0;
                pkt_open <= 1'b0;
            end
        end
    end

    // receive path, periodic listen and serial output
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            rx_busy <= 1'b0;
            listen <= 1'b0;
            wor_cnt <= 24'h0;
            O_RADIO_RX_ENABLE <= 1'b0;
            O_RADIO_RX_READY <= 1'b0;
            O_SER_TX_VALID <= 1'b0;
            O_SER_TX_DATA <= 8'h00;
        end else begin
            O_RADIO_RX_ENABLE <= rx_on;
            O_RADIO_RX_READY <= rx_on && !next_ser_valid;
            O_SER_TX_VALID <= next_ser_valid;
            if (rx_take && rx_ok) begin
                O_SER_TX_DATA <= I_RADIO_RX_DATA;
            end
            if (rx_take) begin
                rx_busy <= !I_RADIO_RX_LAST;
            end
            if (!is_save || !in_run) begin
                listen <= 1'b0;
                wor_cnt <= 24'h0;
            end else if (!rx_busy) begin
                if (wor_cnt == (listen ? 24'(LISTEN_CYCLES - 1) :
                                24'(SLEEP_CYCLES - 1))) begin
                    listen <= !listen;
                    wor_cnt <= 24'h0;
                end else begin
                    wor_cnt <= wor_cnt + 24'h1;
                end
            end
        end
    end

    // checks and coverage
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);

    recfg_busy_a: assert property (
        state == ST_RECFG |-> !O_IDLE)
        else $error("idle indicator high during reconfiguration");
    recfg_len_a: assert property (
        $rose(state == ST_RECFG) |-> (state == ST_RECFG)[*8])
        else $error("reconfiguration ended too soon");
    mode_defer_a: assert property (
        $changed(O_MODE) |-> $past(O_IDLE) && $past(!busy_any))
        else $error("mode changed while busy");
    mode_stable_a: assert property (
        $changed(req_mode) |-> $past(stab) == `RMMC_STABLE_CYC)
        else $error("mode request taken before stable");
    cfg_radio_off_a: assert property (
        is_cfg && $past(is_cfg) |-> !O_RADIO_RX_ENABLE && !O_RADIO_TX_SEND)
        else $error("radio active in configuration mode");
    cfg_baud_a: assert property (
        is_cfg && $past(is_cfg) |-> O_UART_CFG_FIXED)
        else $error("fixed serial format not forced");
    cfgb_all_a: assert property (
        take && is_cfgb |=> O_CFG_BYTE_VALID && O_CFG_BYTE == $past(fifo_data))
        else $error("byte not passed as command");
    wake_rx_off_a: assert property (
        is_wake && $past(is_wake) |-> !O_RADIO_RX_ENABLE)
        else $error("receiver on in wake-up mode");
    save_no_tx_a: assert property (
        is_save && $past(is_save) |-> !O_RADIO_TX_SEND && !O_RADIO_TX_VALID)
        else $error("transmission in power-saving mode");
    wake_pre_a: assert property (
        O_RADIO_TX_SEND |-> O_RADIO_TX_WAKE == is_wake)
        else $error("wake-up preamble flag wrong");
    pay_cap_a: assert property (
        pkt_open |-> pay_cnt <= limit)
        else $error("payload over limit");
    send_cause_a: assert property (
        $rose(send_req) |-> $past(pay_hit) || $past(gap_hit))
        else $error("send without full packet or timeout");
    bcast_flag_a: assert property (
        O_RADIO_TX_SEND |-> O_RADIO_TX_BCAST == is_bcast(O_RADIO_TX_DEST))
        else $error("broadcast flag wrong");
    save_pre_a: assert property (
        rx_take && is_save && !I_RADIO_RX_WAKE |=> !$rose(O_SER_TX_VALID))
        else $error("packet without preamble accepted");

    pkt_send_c: cover property (is_pkt && O_RADIO_TX_SEND);
    wake_send_c: cover property (is_wake && O_RADIO_TX_SEND);
    recfg_c: cover property ($fell(state == ST_RECFG));
    save_rx_c: cover property (is_save && rx_take && I_RADIO_RX_LAST);
endmodule
`default_nettype wire

/* bench/rmmc_radio_model.sv */
`default_nettype none
module rmmc_radio_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic tx_send,
    output logic tx_ready,
    output var int sends,
    output var int last_len
);
    timeunit 1ns;
    timeprecision 1ns;
    int bytes = 0;
    // buffer takes a byte every other cycle, so the block sees stalls
    always @(posedge clk) begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready) bytes <= bytes + 1;
        if (tx_send) begin
            sends <= sends + 1;
            last_len <= bytes;
            bytes <= 0;
        end
    end
    // quiet start
    initial begin
        tx_ready = 1'b0;
        sends = 0;
        last_len = 0;
    end
endmodule
`default_nettype wire

/* bench/radio_module_mode_control_tb.sv */
`default_nettype none
module radio_module_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rxv = 0, txrdy = 1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, mode = 3'h0, o_mode;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] rxd = 8'h00;
    logic hready, rdy, cfg_v, txv, txr, send, wake, rx_on, idle, fixed;
    logic hresp, bcast, stv, rrdy, rrv = 0, rrw = 0, rrl = 0;
    logic [7:0] ser_q, ser_d, rrd = 8'h00;
    logic [15:0] wake_len, rra = 16'h0000;
    int miscompares = 0, tests_run = 0, cyc = 0, cfg_n = 0, lo, sends, len;
    int ser_n = 0;
    // clock and watchdog, config and serial output pulses counted here
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cfg_v === 1'b1) cfg_n++;
        if (stv === 1'b1) begin
            ser_n++;
            ser_d = ser_q;
        end
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    rmmc_top #(.GAP_CYCLES(20), .RECFG_CYCLES(16), .SLEEP_CYCLES(40),
        .LISTEN_CYCLES(10)) dut_u (
        .I_MCLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
        .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_MODE_SELECT_BIT2(mode[2]), .I_MODE_SELECT_BIT1(mode[1]),
        .I_MODE_SELECT_BIT0(mode[0]), .I_SER_RX_VALID(rxv),
        .I_SER_RX_DATA(rxd), .O_SER_RX_READY(rdy), .O_SER_TX_VALID(stv),
        .O_SER_TX_DATA(ser_q), .I_SER_TX_READY(txrdy),
        .O_UART_CFG_FIXED(fixed),
        .O_CFG_BYTE_VALID(cfg_v), .O_CFG_BYTE(), .O_RADIO_TX_VALID(txv),
        .O_RADIO_TX_DATA(), .I_RADIO_TX_READY(txr), .O_RADIO_TX_SEND(send),
        .O_RADIO_TX_WAKE(wake), .O_RADIO_WAKE_LEN(wake_len),
        .O_RADIO_TX_BCAST(bcast), .O_RADIO_TX_DEST(),
        .O_RADIO_RX_ENABLE(rx_on),
        .I_RADIO_RX_VALID(rrv), .I_RADIO_RX_DATA(rrd),
        .I_RADIO_RX_ADDR(rra), .I_RADIO_RX_WAKE(rrw),
        .I_RADIO_RX_LAST(rrl), .O_RADIO_RX_READY(rrdy), .O_IDLE(idle),
        .O_MODE(o_mode));
    rmmc_radio_model rad_u (.clk(clk), .tx_valid(txv), .tx_send(send),
        .tx_ready(txr), .sends(sends), .last_len(len));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk(hresp, 0);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // one serial byte, held until taken
    task automatic ser(input logic [7:0] d);
        @(posedge clk);
        rxv <= 1'b1;
        rxd <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rxv <= 1'b0;
    endtask
    // new pin code, then wait for adoption and the busy line to rise
    task automatic set_mode(input logic [2:0] m);
        lo = 0;
        @(posedge clk);
        mode <= m;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk);
            if (idle === 1'b0) lo++;
            if (n > 40 && o_mode === m && idle === 1'b1) break;
        end
    endtask
    task automatic wait_send(input int s);
        for (int n = 0; n < 600 && sends == s; n++) @(posedge clk);
    endtask
    // one radio packet into the receiver, then count the serial output
    task automatic rx(input logic [15:0] a, input logic w, input int n,
            input int e);
        int s;
        s = ser_n;
        @(posedge clk);
        rra <= a;
        rrw <= w;
        rrv <= 1'b1;
        for (int i = 0; i < n; i++) begin
            rrd <= 8'(8'h90 + i);
            rrl <= (i == n - 1);
            do @(posedge clk); while (rrdy !== 1'b1);
        end
        rrv <= 1'b0;
        rrl <= 1'b0;
        repeat (3) @(posedge clk);
        chk(ser_n - s, e);
        if (e > 0) chk(ser_d, 8'(8'h90 + n - 1));
    endtask
    // reset values of the channel, wake and address shadow registers, then an unmapped word
    task automatic t_regs();
        rchk(8'h08, 32'h04);
        rchk(8'h0C, 32'h10);
        rchk(8'h04, 32'h0);
        rchk(8'h40, 32'h0);
    endtask
    // mode 101: every byte is a command, shadows written
    task automatic t_cfgb();
        int s;
        set_mode(3'h5);
        chk(fixed, 1);
        chk(rx_on, 0);
        s = cfg_n;
        ser(8'h11);
        ser(8'h00);
        repeat (4) @(posedge clk);
        chk(cfg_n - s, 2);
        bus(1'b1, 8'h04, 32'h1234);
        rchk(8'h04, 32'h1234);
        bus(1'b1, 8'h08, 32'h64);
        bus(1'b1, 8'h0C, 32'h20);
    endtask
    // mode 010: reconfiguration, size cap, gap timeout, receive filter
    task automatic t_pkt();
        int s;
        set_mode(3'h2);
        chk(lo >= 16 && lo < 24, 1);
        chk(wake_len, 32'h20);
        chk(rx_on, 1);
        s = sends;
        repeat (32) ser(8'h5A);
        wait_send(s);
        chk(len, 32);
        chk(bcast, 0);
        s = sends;
        repeat (3) ser(8'hA5);
        wait_send(s);
        chk(len, 3);
        chk(wake, 0);
        rx(16'h1234, 1'b0, 2, 2);
        rx(16'h5678, 1'b0, 1, 0);
        rx(16'hFFFF, 1'b0, 1, 1);
    endtask
    // mode 100: receiver off, 84 byte cap, preamble flag
    task automatic t_wake();
        int s;
        set_mode(3'h4);
        chk(rx_on, 0);
        s = sends;
        repeat (85) ser(8'h33);
        wait_send(s);
        chk(len, 84);
        chk(wake, 1);
    endtask
    // mode 110: no sending, periodic listen, preamble filter
    task automatic t_save();
        int s, on;
        set_mode(3'h6);
        s = sends;
        on = 0;
        ser(8'h44);
        repeat (100) begin
            @(posedge clk);
            if (rx_on === 1'b1) on++;
        end
        chk(sends - s, 0);
        chk(on > 0 && on < 100, 1);
        rx(16'h1234, 1'b0, 1, 0);
        rx(16'h1234, 1'b1, 2, 2);
    endtask
    // mode 011: only command heads and their trailing bytes pass
    task automatic t_cfga();
        int s;
        set_mode(3'h3);
        s = cfg_n;
        ser(8'h11);
        repeat (3) ser(8'hC1);
        repeat (4) @(posedge clk);
        chk(cfg_n - s, 3);
    endtask
    // scenarios in order
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_cfgb();
        t_pkt();
        t_wake();
        t_save();
        t_cfga();
        print_verdict();
    end
endmodule
`default_nettype wire
